// ---- mcg_pkg.sv ----
package mcg_pkg;
   localparam logic [7:0] CFG_CAP_HEADER = 8'h50;
   localparam logic [7:0] CFG_LINK_PTR = 8'h51;
   localparam logic [7:0] CFG_MSG_CTRL = 8'h52;
   localparam logic [7:0] CFG_ADDR_LOW = 8'h54;
   localparam logic [7:0] CFG_ADDR_HIGH = 8'h58;
   localparam logic [7:0] CFG_PAYLOAD = 8'h5C;
   localparam logic [7:0] CAP_ID_VALUE = 8'h05;
   localparam logic [7:0] LINK_PTR_VALUE = 8'h70;
   localparam logic [15:0] MSG_CTRL_RESET = 16'h0088;
   localparam logic [2:0] COUNT_CAPABLE = 3'b100;
   localparam logic [2:0] COUNT_MAX_CODE = 3'b100;
   localparam int CTRL_WIDE_BIT = 7;
   localparam int CTRL_ENABLE_BIT = 0;
   localparam logic [31:0] ADDR_RESET = 32'h0000_0000;
   localparam logic [15:0] PAYLOAD_RESET = 16'h0000;

   typedef struct packed {
      logic [7:0] addr;
      logic [3:0] be;
      logic [31:0] data;
      logic wr;
      logic rd;
   } mcg_cfg_req_s;

   typedef struct packed {
      logic [63:0] addr;
      logic wide;
      logic [31:0] data;
   } mcg_msg_s;
endpackage

// ---- mcg_msi_cap.sv ----
`timescale 1ns/100ps
module mcg_msi_cap
   import mcg_pkg::*;
(
   input wire logic CORE_CLK,
   input wire logic RST_N,
   input wire mcg_pkg::mcg_cfg_req_s CFG_REQ,
   output logic [31:0] CFG_RDATA,
   output logic CFG_RVALID,
   input wire logic IRQ_DETECT,
   input wire logic [3:0] IRQ_VECTOR,
   output logic IRQ_TAKEN,
   output logic MSG_VALID,
   input wire logic MSG_READY,
   output mcg_pkg::mcg_msg_s MSG_OUT
);
   import mcg_pkg::*;

   logic [2:0] count_enable;
   logic msg_enable;
   logic [31:2] addr_low;
   logic [31:0] addr_high;
   logic [15:0] payload;
   logic [31:0] next_rdata;

   function automatic logic [15:0] compose(input logic [15:0] base,
                                           input logic [2:0] code,
                                           input logic [3:0] vec);
      logic [3:0] keep;
      keep = 4'hF;
      unique case (code)
         3'b001: keep = 4'hE;
         3'b010: keep = 4'hC;
         3'b011: keep = 4'h8;
         3'b100: keep = 4'h0;
         default: keep = 4'hF;
      endcase
      compose = {base[15:4], (base[3:0] & keep) | (vec & ~keep)};
   endfunction

   // word-aligned config dword view; byte enables steer writes
   always_ff @(posedge CORE_CLK) begin
      if (!RST_N) begin
         count_enable <= MSG_CTRL_RESET[6:4];
         msg_enable <= 1'b0;
      end else if (CFG_REQ.wr && CFG_REQ.addr == CFG_CAP_HEADER
                   && CFG_REQ.be[2]) begin
         if (CFG_REQ.data[22:20] <= COUNT_MAX_CODE)
            count_enable <= CFG_REQ.data[22:20];
         msg_enable <= CFG_REQ.data[16];
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (!RST_N) begin
         addr_low <= ADDR_RESET[31:2];
         addr_high <= ADDR_RESET;
         payload <= PAYLOAD_RESET;
      end else if (CFG_REQ.wr) begin
         for (int b = 0; b < 4; b++) begin
            if (CFG_REQ.be[b] && CFG_REQ.addr == CFG_ADDR_HIGH)
               addr_high[b*8 +: 8] <= CFG_REQ.data[b*8 +: 8];
         end
         if (CFG_REQ.addr == CFG_ADDR_LOW) begin
            if (CFG_REQ.be[0])
               addr_low[7:2] <= CFG_REQ.data[7:2];
            for (int b = 1; b < 4; b++) begin
               if (CFG_REQ.be[b])
                  addr_low[b*8 +: 8] <= CFG_REQ.data[b*8 +: 8];
            end
         end
         if (CFG_REQ.addr == CFG_PAYLOAD) begin
            if (CFG_REQ.be[0])
               payload[7:0] <= CFG_REQ.data[7:0];
            if (CFG_REQ.be[1])
               payload[15:8] <= CFG_REQ.data[15:8];
         end
      end
   end

   always_comb begin
      next_rdata = 32'h0000_0000;
      unique case (CFG_REQ.addr)
         CFG_CAP_HEADER: begin
            next_rdata[7:0] = CAP_ID_VALUE;
            next_rdata[15:8] = LINK_PTR_VALUE;
            next_rdata[CTRL_WIDE_BIT+16] = 1'b1;
            next_rdata[22:20] = count_enable;
            next_rdata[19:17] = COUNT_CAPABLE;
            next_rdata[CTRL_ENABLE_BIT+16] = msg_enable;
         end
         CFG_ADDR_LOW: next_rdata = {addr_low, 2'b00};
         CFG_ADDR_HIGH: next_rdata = addr_high;
         CFG_PAYLOAD: next_rdata = {16'h0000, payload};
         default: next_rdata = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge CORE_CLK) begin
      if (!RST_N) begin
         CFG_RDATA <= 32'h0000_0000;
         CFG_RVALID <= 1'b0;
      end else begin
         CFG_RVALID <= CFG_REQ.rd;
         CFG_RDATA <= CFG_REQ.rd ? next_rdata : 32'h0000_0000;
      end
   end

   // one message in flight; irq held off while busy or disabled
   always_ff @(posedge CORE_CLK) begin
      if (!RST_N) begin
         MSG_VALID <= 1'b0;
         MSG_OUT <= '0;
         IRQ_TAKEN <= 1'b0;
      end else begin
         IRQ_TAKEN <= 1'b0;
         if (MSG_VALID && MSG_READY)
            MSG_VALID <= 1'b0;
         else if (!MSG_VALID && IRQ_DETECT && msg_enable) begin
            MSG_VALID <= 1'b1;
            IRQ_TAKEN <= 1'b1;
            MSG_OUT.addr <= {addr_high, addr_low, 2'b00};
            MSG_OUT.wide <= |addr_high;
            MSG_OUT.data <= {16'h0000,
                             compose(payload, count_enable, IRQ_VECTOR)};
         end
      end
   end

   // message path checks
   a_enable_gates: assert property (
      @(posedge CORE_CLK) disable iff (!RST_N)
      !msg_enable && !MSG_VALID |=> !MSG_VALID)
      else $error("message sent while disabled");
   a_disabled_quiet: assert property (
      @(posedge CORE_CLK) disable iff (!RST_N)
      !msg_enable |=> !IRQ_TAKEN)
      else $error("irq taken while disabled");
   a_take_irq: assert property (
      @(posedge CORE_CLK) disable iff (!RST_N)
      IRQ_DETECT && msg_enable && !MSG_VALID |=> MSG_VALID && IRQ_TAKEN)
      else $error("irq not turned into message");
   a_busy_refuse: assert property (
      @(posedge CORE_CLK) disable iff (!RST_N)
      MSG_VALID |=> !IRQ_TAKEN)
      else $error("irq taken while message pending");
   a_msg_hold: assert property (
      @(posedge CORE_CLK) disable iff (!RST_N)
      MSG_VALID && !MSG_READY |=> MSG_VALID && $stable(MSG_OUT))
      else $error("pending message changed");
   a_wide_flag: assert property (
      @(posedge CORE_CLK) disable iff (!RST_N)
      MSG_VALID |-> MSG_OUT.wide == (MSG_OUT.addr[63:32] != 32'h0000_0000))
      else $error("address width flag wrong");
   a_addr_align: assert property (
      @(posedge CORE_CLK) disable iff (!RST_N)
      MSG_VALID |-> MSG_OUT.addr[1:0] == 2'b00)
      else $error("message address unaligned");
   a_data_upper: assert property (
      @(posedge CORE_CLK) disable iff (!RST_N)
      IRQ_TAKEN
      |-> (MSG_OUT.data[15:0] & 16'hFFF0) == ($past(payload) & 16'hFFF0)
      && MSG_OUT.data[31:16] == 16'h0000)
      else $error("fixed payload bits altered");

   // vector substitution for count codes 000, 001, 011 and 100 (code 010 not checked)
   a_single_vec: assert property (
      @(posedge CORE_CLK) disable iff (!RST_N)
      IRQ_TAKEN && $past(count_enable) == 3'b000
      |-> MSG_OUT.data[3:0] == 4'($past(payload)))
      else $error("vector bits changed for one message");
   a_two_vec: assert property (
      @(posedge CORE_CLK) disable iff (!RST_N)
      IRQ_TAKEN && $past(count_enable) == 3'b001
      |-> MSG_OUT.data[3:0] == ((4'($past(payload)) & 4'hE)
      | ($past(IRQ_VECTOR) & 4'h1)))
      else $error("two vector substitution wrong");
   a_eight_vec: assert property (
      @(posedge CORE_CLK) disable iff (!RST_N)
      IRQ_TAKEN && $past(count_enable) == 3'b011
      |-> MSG_OUT.data[3:0] == ((4'($past(payload)) & 4'h8)
      | ($past(IRQ_VECTOR) & 4'h7)))
      else $error("eight vector substitution wrong");
   a_sixteen_vec: assert property (
      @(posedge CORE_CLK) disable iff (!RST_N)
      IRQ_TAKEN && $past(count_enable) == 3'b100
      |-> MSG_OUT.data[3:0] == $past(IRQ_VECTOR))
      else $error("vector number not substituted");

   // register read checks and count_enable legality
   a_ctrl_read: assert property (
      @(posedge CORE_CLK) disable iff (!RST_N)
      CFG_REQ.rd && CFG_REQ.addr == CFG_CAP_HEADER
      |=> CFG_RVALID && CFG_RDATA[15:0] == 16'h7005
      && CFG_RDATA[31:24] == 8'h00 && CFG_RDATA[23]
      && CFG_RDATA[19:17] == 3'b100)
      else $error("capability header read wrong");
   a_enable_read: assert property (
      @(posedge CORE_CLK) disable iff (!RST_N)
      CFG_REQ.rd && CFG_REQ.addr == CFG_CAP_HEADER
      |=> CFG_RDATA[16] == $past(msg_enable))
      else $error("enable bit read wrong");
   a_low_read: assert property (
      @(posedge CORE_CLK) disable iff (!RST_N)
      CFG_REQ.rd && CFG_REQ.addr == CFG_ADDR_LOW
      |=> CFG_RVALID && CFG_RDATA[1:0] == 2'b00)
      else $error("low address reserved bits set");
   a_high_read: assert property (
      @(posedge CORE_CLK) disable iff (!RST_N)
      CFG_REQ.rd && CFG_REQ.addr == CFG_ADDR_HIGH
      |=> CFG_RVALID && CFG_RDATA == $past(addr_high))
      else $error("high address read wrong");
   a_payload_read: assert property (
      @(posedge CORE_CLK) disable iff (!RST_N)
      CFG_REQ.rd && CFG_REQ.addr == CFG_PAYLOAD
      |=> CFG_RVALID && CFG_RDATA[31:16] == 16'h0000)
      else $error("payload read upper half set");
   a_count_legal: assert property (
      @(posedge CORE_CLK) disable iff (!RST_N)
      count_enable <= 3'b100)
      else $error("reserved vector count held");
endmodule

// ---- mcg_msg_sink.sv ----
`timescale 1ns/100ps
module mcg_msg_sink
   import mcg_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic slow,
   input wire logic valid,
   input wire mcg_pkg::mcg_msg_s msg,
   output logic ready,
   output mcg_pkg::mcg_msg_s got,
   output int n_got
);
   // slow mode accepts only every other cycle
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ready <= 1'b0;
         n_got <= 0;
      end else begin
         ready <= slow ? ~ready : 1'b1;
         if (valid && ready) begin
            got <= msg;
            n_got <= n_got + 1;
         end
      end
   end
endmodule

// ---- msi_capability_generator_bench.sv ----
`timescale 1ns/100ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin fail_count++; \
 $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module msi_capability_generator_bench;
   import mcg_pkg::*;
   logic CORE_CLK = 0, RST_N = 0, IRQ_DETECT = 0, slow = 0;
   logic [3:0] IRQ_VECTOR = '0, v;
   mcg_cfg_req_s CFG_REQ = '0;
   logic [31:0] CFG_RDATA;
   logic CFG_RVALID, IRQ_TAKEN, MSG_VALID, MSG_READY;
   mcg_msg_s MSG_OUT, got;
   logic [15:0] m;
   int n_got, fail_count = 0, n_compared = 0, cyc = 0, n_taken = 0, n0;
   always #50 CORE_CLK = ~CORE_CLK;
   mcg_msi_cap dut (.CORE_CLK(CORE_CLK), .RST_N(RST_N), .CFG_REQ(CFG_REQ),
      .CFG_RDATA(CFG_RDATA), .CFG_RVALID(CFG_RVALID),
      .IRQ_DETECT(IRQ_DETECT), .IRQ_VECTOR(IRQ_VECTOR), .IRQ_TAKEN(IRQ_TAKEN),
      .MSG_VALID(MSG_VALID), .MSG_READY(MSG_READY), .MSG_OUT(MSG_OUT));
   mcg_msg_sink host (.clk(CORE_CLK), .rst_n(RST_N), .slow(slow),
      .valid(MSG_VALID), .msg(MSG_OUT), .ready(MSG_READY), .got(got),
      .n_got(n_got));
   task automatic close_out;
      $display("compared %0d failed %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   always @(negedge CORE_CLK) begin
      cyc++;
      if (IRQ_TAKEN === 1'b1) n_taken++;
      if (cyc == 3000) begin
         fail_count++;
         close_out();
      end
   end
   task automatic wr(input logic [7:0] a, input logic [3:0] b,
         input logic [31:0] d);
      @(posedge CORE_CLK);
      CFG_REQ <= '{a, b, d, 1'b1, 1'b0};
      @(posedge CORE_CLK);
      CFG_REQ <= '0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge CORE_CLK);
      CFG_REQ <= '{a, 4'hF, 32'h0, 1'b0, 1'b1};
      @(posedge CORE_CLK);
      CFG_REQ <= '0;
      #1;
      `CHK(CFG_RVALID, 1'b1)
      `CHK(CFG_RDATA, e)
   endtask
   // hold detect until taken, then wait for the host to accept
   task automatic irq;
      n0 = n_got;
      @(posedge CORE_CLK);
      IRQ_DETECT <= 1'b1;
      IRQ_VECTOR <= v;
      repeat (10) begin
         @(negedge CORE_CLK);
         if (IRQ_TAKEN === 1'b1) break;
      end
      @(posedge CORE_CLK);
      IRQ_DETECT <= 1'b0;
      repeat (20) if (n_got == n0) @(negedge CORE_CLK);
      `CHK(n_got, n0 + 1)
   endtask
   initial begin
      repeat (12) @(posedge CORE_CLK);
      RST_N <= 1'b1;
      rd(8'h50, 32'h0088_7005);
      rd(8'h54, 32'h0);
      rd(8'h58, 32'h0);
      rd(8'h5C, 32'h0);
      rd(8'h60, 32'h0);
      wr(8'h50, 4'hF, 32'hFFFF_FFFF);
      rd(8'h50, 32'h0089_7005);
      wr(8'h54, 4'hF, 32'h1234_567B);
      rd(8'h54, 32'h1234_5678);
      wr(8'h5C, 4'hF, 32'hFFFF_ABC5);
      rd(8'h5C, 32'h0000_ABC5);
      wr(8'h60, 4'hF, 32'hFFFF_FFFF);
      rd(8'h60, 32'h0);
      $display("test registers done");
      for (int k = 0; k <= 4; k++) begin
         slow <= k[0];
         m = 16'hFFFF << k;
         v = 4'hA + 4'(k);
         wr(8'h50, 4'h4, 32'h0001_0000 | (k << 20));
         wr(8'h58, 4'hF, 32'(k));
         rd(8'h58, 32'(k));
         irq();
         `CHK(got.data, {16'h0, 16'hABC5 & m | {12'h0, v} & ~m})
         `CHK(got.addr, {32'(k), 32'h1234_5678})
         `CHK(got.wide, k != 0)
      end
      `CHK(n_taken, 5)
      $display("test messages done");
      wr(8'h50, 4'h4, 32'h0);
      n0 = n_taken;
      IRQ_DETECT <= 1'b1;
      repeat (6) @(posedge CORE_CLK);
      IRQ_DETECT <= 1'b0;
      repeat (4) @(posedge CORE_CLK);
      `CHK(n_taken, n0)
      `CHK(n_got, 5)
      $display("test disabled done");
      close_out();
   end
endmodule
